// ### core/flash_runtime_self_programming_pkg.sv
package flash_runtime_self_programming_pkg;

  localparam int ROW_WORDS      = 32;
  localparam int ROWS_PER_PANEL = 128;
  localparam int PANEL_WORDS    = ROW_WORDS * ROWS_PER_PANEL;
  localparam int ADDR_W         = 24;
  localparam int WORD_W         = 24;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Flash operation control register layout.
  localparam int          CTRL_WR_BIT    = 15;
  localparam int          CTRL_WRITE_ENABLE_BIT_BIT  = 14;
  localparam int          CTRL_ERASE_BIT = 6;
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_MODE_W    = 4;
  localparam logic [3:0]  CTRL_MODE_ROW  = 4'h1;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK   = 16'h404f;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0]  ADDR_HIGH_RESET = 8'h00;
  localparam logic [23:0] ERASED_WORD    = 24'hffffff;

  // Timing.
  localparam int OP_TIME_US   = 2000;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int OP_CYCLES    = OP_TIME_US * CLK_FREQ_MHZ;
  localparam int TABLE_WRITE_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_TBL_WT_LO = 3'h0,
    OP_TBL_WT_HI = 3'h1,
    OP_TBL_RD_LO = 3'h2,
    OP_TBL_RD_HI = 3'h3,
    OP_SFR_WR    = 3'h4,
    OP_SFR_RD    = 3'h5
  } core_op_t;

  typedef enum logic [1:0] {
    SFR_CONTROL   = 2'h0,
    SFR_ADDR_LOW  = 2'h1,
    SFR_ADDR_HIGH = 2'h2,
    SFR_KEY       = 2'h3
  } sfr_sel_t;

  // APB register map of the core end.
  localparam logic [7:0] APB_CMD     = 8'h00;
  localparam logic [7:0] APB_EA      = 8'h04;
  localparam logic [7:0] APB_PAGE    = 8'h08;
  localparam logic [7:0] APB_WDATA   = 8'h0c;
  localparam logic [7:0] APB_RDATA   = 8'h10;
  localparam logic [7:0] APB_STATUS  = 8'h14;
  localparam logic [7:0] APB_IRQ_ST  = 8'h18;
  localparam logic [7:0] APB_IRQ_MSK = 8'h1c;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BYTE_BIT = 3;
  localparam int CMD_SEL_LSB  = 4;
  localparam int STAT_PEND_BIT  = 0;
  localparam int STAT_STALL_BIT = 1;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_OPEND_BIT  = 1;
  localparam logic [1:0] IRQ_RESET = 2'b00;

endpackage : flash_runtime_self_programming_pkg

// ### core/flash_runtime_self_programming_if.sv
`timescale 1ns/10ps
interface flash_runtime_self_programming_if;
  import flash_runtime_self_programming_pkg::*;

  logic        req;
  core_op_t    op;
  sfr_sel_t    sel;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic        byte_mode;
  logic        ack;
  logic [15:0] rdata;
  logic        stall;

  modport device (input req, op, sel, addr, wdata, byte_mode, output ack, rdata, stall);
  modport core   (output req, op, sel, addr, wdata, byte_mode, input ack, rdata, stall);

endinterface : flash_runtime_self_programming_if

// ### core/flash_runtime_self_programming_device.sv
`timescale 1ns/10ps
// Summary of operation
// - Rows hold 32 words; erase one row
// - Panels of 128 rows, own write latches
// - Latches hold 32 words, filled before program
// - Latches loaded in order within aligned row
// - Low table ops reach bits 15:0
// - High table ops reach bits 23:16
// - Address is page byte plus effective address
// - Table write takes two cycles, latches only
// - Low address register captures EA 15:0
// - High address register captures EA 23:16
// - Software may write both address registers
// - Key is write-only: 0x55 then 0xAA
// - Operation lasts 2 ms, core stalls
// - Bit 15 starts operation, self-clears
// - Erase: configure, address, key, start
// - Program: configure, key, start, commits latches
// - Core issues two no-ops after start; this core issues no request until the start is answered
module flash_runtime_self_programming_device
  import flash_runtime_self_programming_pkg::*;
#(
  parameter int NUM_PANELS  = 1,
  parameter int OP_CYCLES_P = OP_CYCLES
) (
  input  wire logic     pclk,
  input  wire logic     presetn,
  flash_runtime_self_programming_if.device  link,
  output logic          op_busy,
  output logic          op_done
);

  localparam int FLASH_WORDS = NUM_PANELS * PANEL_WORDS;
  localparam int FW          = $clog2(FLASH_WORDS);

  // Refuse at elaboration what the address masks and the row copy cannot serve.
  if (NUM_PANELS < 1 || (NUM_PANELS & (NUM_PANELS - 1)) != 0) begin : g_bad_panels
    $error("NUM_PANELS must be a power of two");
  end
  if (OP_CYCLES_P < ROW_WORDS + 2) begin : g_bad_cycles
    $error("OP_CYCLES_P too short for a row");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TABLE_WRITE = 3'b010,
    ST_OP    = 3'b100
  } dev_state_t;

  // Program memory counts two address units per instruction word.
  function automatic int word_index(input logic [23:0] a);
    word_index = int'(a[23:1]) & (FLASH_WORDS - 1);
  endfunction : word_index

  function automatic int latch_base(input logic [23:0] a);
    latch_base = (word_index(a) / PANEL_WORDS) * ROW_WORDS;
  endfunction : latch_base

  logic [23:0] flash_mem [FLASH_WORDS];
  logic [23:0] latch_mem [NUM_PANELS * ROW_WORDS];

  dev_state_t  state_r;
  logic [15:0] ctrl_r;
  logic [15:0] addr_low_r;
  logic [7:0]  addr_high_r;
  logic [1:0]  key_stage_r;
  logic [31:0] op_cnt_r;
  logic        ack_r;
  logic [15:0] rdata_r;
  logic        stall_r;
  logic        done_r;

  logic        take;
  logic        tbl_op;
  logic        sfr_wr;
  logic        start_ok;
  logic [23:0] target;
  logic [23:0] cur_word;
  logic        op_last;

  assign take     = (state_r == ST_IDLE) && link.req;
  assign tbl_op   = (link.op == OP_TBL_WT_LO) || (link.op == OP_TBL_WT_HI) ||
                    (link.op == OP_TBL_RD_LO) || (link.op == OP_TBL_RD_HI);
  assign sfr_wr   = take && (link.op == OP_SFR_WR);
  // A start needs the enable bit in the same write and the full key just before it.
  assign start_ok = sfr_wr && (link.sel == SFR_CONTROL) && link.wdata[CTRL_WR_BIT] &&
                    link.wdata[CTRL_WRITE_ENABLE_BIT_BIT] && (key_stage_r == 2'd2) &&
                    (link.wdata[CTRL_MODE_LSB +: CTRL_MODE_W] == CTRL_MODE_ROW);
  assign target   = {addr_high_r, addr_low_r};
  assign cur_word = flash_mem[word_index(link.addr)];
  assign op_last  = (op_cnt_r == 32'(OP_CYCLES_P - 1));

  // Sequencer state and operation timer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= ST_IDLE;
      op_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          op_cnt_r <= 32'h0;
          if (take && (link.op == OP_TBL_WT_LO || link.op == OP_TBL_WT_HI))
            state_r <= ST_TABLE_WRITE;
          else if (start_ok)
            state_r <= ST_OP;
        end
        ST_TABLE_WRITE: state_r <= ST_IDLE;
        ST_OP: begin
          op_cnt_r <= op_cnt_r + 32'h1;
          if (op_last)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Control and address registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= CTRL_RESET;
      addr_low_r  <= ADDR_LOW_RESET;
      addr_high_r <= ADDR_HIGH_RESET;
    end else begin
      if (take && tbl_op) begin
        addr_low_r  <= link.addr[15:0];
        addr_high_r <= link.addr[23:16];
      end
      if (sfr_wr) begin
        case (link.sel)
          SFR_CONTROL: begin
            ctrl_r <= link.wdata & CTRL_WR_MASK;
            ctrl_r[CTRL_WR_BIT] <= start_ok;
          end
          SFR_ADDR_LOW:  addr_low_r  <= link.wdata;
          SFR_ADDR_HIGH: addr_high_r <= link.wdata[7:0];
          default: ;
        endcase
      end
      if (state_r == ST_OP && op_last)
        ctrl_r[CTRL_WR_BIT] <= 1'b0;
    end
  end

  // Unlock key tracker; any register write that is not the expected next key step rewinds it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_stage_r <= 2'd0;
    end else if (sfr_wr) begin
      if (link.sel == SFR_KEY && link.wdata[7:0] == KEY_FIRST)
        key_stage_r <= 2'd1;
      else if (link.sel == SFR_KEY && link.wdata[7:0] == KEY_SECOND && key_stage_r == 2'd1)
        key_stage_r <= 2'd2;
      else
        key_stage_r <= 2'd0;
    end
  end

  // Panel write latches. The core must walk one aligned row in order, so only the
  // word offset inside the row and the panel select the latch.
  always_ff @(posedge pclk) begin
    if (take && link.op == OP_TBL_WT_LO) begin
      if (!link.byte_mode)
        latch_mem[latch_base(link.addr) + int'(link.addr[5:1])][15:0] <= link.wdata;
      else if (link.addr[0])
        latch_mem[latch_base(link.addr) + int'(link.addr[5:1])][15:8] <= link.wdata[7:0];
      else
        latch_mem[latch_base(link.addr) + int'(link.addr[5:1])][7:0] <= link.wdata[7:0];
    end
    if (take && link.op == OP_TBL_WT_HI && !(link.byte_mode && link.addr[0]))
      latch_mem[latch_base(link.addr) + int'(link.addr[5:1])][23:16] <= link.wdata[7:0];
  end

  // Flash array: one row word per cycle during the first cycles of an operation.
  always_ff @(posedge pclk) begin
    if (state_r == ST_OP && op_cnt_r < 32'(ROW_WORDS)) begin
      if (ctrl_r[CTRL_ERASE_BIT])
        flash_mem[(word_index(target) & ~(ROW_WORDS - 1)) + int'(op_cnt_r[4:0])] <= ERASED_WORD;
      else
        flash_mem[(word_index(target) & ~(ROW_WORDS - 1)) + int'(op_cnt_r[4:0])] <=
          latch_mem[latch_base(target) + int'(op_cnt_r[4:0])];
    end
  end

  // Answers to the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r   <= 1'b0;
      rdata_r <= 16'h0;
      stall_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      ack_r  <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take && !start_ok && link.op != OP_TBL_WT_LO && link.op != OP_TBL_WT_HI)
            ack_r <= 1'b1;
          if (start_ok)
            stall_r <= 1'b1;
          if (take) begin
            case (link.op)
              OP_TBL_RD_LO: begin
                if (!link.byte_mode)
                  rdata_r <= cur_word[15:0];
                else if (link.addr[0])
                  rdata_r <= {8'h00, cur_word[15:8]};
                else
                  rdata_r <= {8'h00, cur_word[7:0]};
              end
              OP_TBL_RD_HI: rdata_r <= (link.byte_mode && link.addr[0]) ? 16'h0 : {8'h00, cur_word[23:16]};
              OP_SFR_RD: begin
                case (link.sel)
                  SFR_CONTROL:   rdata_r <= ctrl_r;
                  SFR_ADDR_LOW:  rdata_r <= addr_low_r;
                  SFR_ADDR_HIGH: rdata_r <= {8'h00, addr_high_r};
                  default:       rdata_r <= 16'h0;
                endcase
              end
              default: ;
            endcase
          end
        end
        ST_TABLE_WRITE: ack_r <= 1'b1;
        ST_OP: begin
          if (op_last) begin
            stall_r <= 1'b0;
            ack_r   <= 1'b1;
            done_r  <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  assign link.ack   = ack_r;
  assign link.rdata = rdata_r;
  assign link.stall = stall_r;
  assign op_busy    = stall_r;
  assign op_done    = done_r;

endmodule : flash_runtime_self_programming_device

// ### core/flash_runtime_self_programming_core.sv
`timescale 1ns/10ps
// Core end: software fills the effective address, page and data, then writes the
// command word; the core forms the 24-bit address and waits for the answer.
module flash_runtime_self_programming_core
  import flash_runtime_self_programming_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  flash_runtime_self_programming_if.core       link
);

  logic [15:0] ea_r;
  logic [7:0]  page_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [6:0]  cmd_r;
  logic        req_r;
  logic        pend_r;
  logic        stall_d_r;
  logic [1:0]  irq_st_r;
  logic [1:0]  irq_msk_r;
  logic        irq_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [1:0]  events;

  assign access = psel && penable && !pready_r;
  assign wr_en  = psel && penable && pready_r && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= APB_IRQ_MSK);
  assign events = {stall_d_r && !link.stall, link.ack};

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= access;
      pslverr_r <= access && !mapped;
      prdata_r  <= 32'h0;
      if (access && !pwrite) begin
        case (paddr)
          APB_CMD:     prdata_r <= {25'h0, cmd_r};
          APB_EA:      prdata_r <= {16'h0, ea_r};
          APB_PAGE:    prdata_r <= {24'h0, page_r};
          APB_WDATA:   prdata_r <= {16'h0, wdata_r};
          APB_RDATA:   prdata_r <= {16'h0, rdata_r};
          APB_STATUS:  prdata_r <= {30'h0, link.stall, pend_r};
          APB_IRQ_ST:  prdata_r <= {30'h0, irq_st_r};
          APB_IRQ_MSK: prdata_r <= {30'h0, irq_msk_r};
          default:     prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // Software registers. A command written while one is pending is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_r      <= 16'h0;
      page_r    <= 8'h0;
      wdata_r   <= 16'h0;
      cmd_r     <= 7'h0;
      irq_msk_r <= IRQ_RESET;
    end else if (wr_en) begin
      case (paddr)
        APB_CMD:     if (!pend_r) cmd_r <= pwdata[6:0];
        APB_EA:      ea_r      <= pwdata[15:0];
        APB_PAGE:    page_r    <= pwdata[7:0];
        APB_WDATA:   wdata_r   <= pwdata[15:0];
        APB_IRQ_MSK: irq_msk_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Request issue and completion; the core stays stalled until the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r     <= 1'b0;
      pend_r    <= 1'b0;
      rdata_r   <= 16'h0;
      stall_d_r <= 1'b0;
    end else begin
      stall_d_r <= link.stall;
      req_r     <= wr_en && (paddr == APB_CMD) && !pend_r;
      if (wr_en && (paddr == APB_CMD) && !pend_r)
        pend_r <= 1'b1;
      else if (link.ack)
        pend_r <= 1'b0;
      if (link.ack)
        rdata_r <= link.rdata;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= IRQ_RESET;
      irq_r    <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~((wr_en && paddr == APB_IRQ_ST) ? pwdata[1:0] : 2'b00)) | events;
      irq_r    <= |(irq_st_r & irq_msk_r);
    end
  end

  assign link.req       = req_r;
  assign link.op        = core_op_t'(cmd_r[CMD_OP_LSB +: 3]);
  assign link.byte_mode = cmd_r[CMD_BYTE_BIT];
  assign link.sel       = sfr_sel_t'(cmd_r[CMD_SEL_LSB +: 2]);
  assign link.addr      = {page_r, ea_r};
  assign link.wdata     = wdata_r;
  assign pready         = pready_r;
  assign prdata         = prdata_r;
  assign pslverr        = pslverr_r;
  assign irq            = irq_r;

endmodule : flash_runtime_self_programming_core

// ### test/flash_runtime_self_programming_props.sv
`timescale 1ns/10ps
module flash_runtime_self_programming_props
  import flash_runtime_self_programming_pkg::*;
#(
  parameter int OP_CYCLES_P = OP_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire core_op_t    op,
  input wire sfr_sel_t    sel,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        stall,
  input wire logic        op_busy,
  input wire logic        op_done
);
  logic [1:0]  key_r;
  logic [31:0] stall_cnt_r;
  logic        sfr_wr;
  logic        go;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any register write other than the next key step throws away a partial key.
  assign sfr_wr = req && op == OP_SFR_WR;
  assign go = sfr_wr && sel == SFR_CONTROL && wdata[15:14] == 2'b11 && wdata[3:0] == CTRL_MODE_ROW && key_r == 2'd2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_r <= 2'd0;
    end else if (sfr_wr && sel == SFR_KEY) begin
      key_r <= (wdata[7:0] == KEY_FIRST) ? 2'd1 : {key_r == 2'd1 && wdata[7:0] == KEY_SECOND, 1'b0};
    end else if (sfr_wr) begin
      key_r <= 2'd0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_r <= 32'd0;
    end else begin
      stall_cnt_r <= stall ? stall_cnt_r + 32'd1 : 32'd0;
    end
  end
  read_answer_a: assert property (req && op inside {OP_TBL_RD_LO, OP_TBL_RD_HI, OP_SFR_RD} |=> ack)
    else $error("read not answered after one cycle");
  table_write_a: assert property (req && op inside {OP_TBL_WT_LO, OP_TBL_WT_HI} |=> !ack ##1 ack)
    else $error("table write not answered after two cycles");
  start_refused_a: assert property (sfr_wr && !go |=> ack && !stall)
    else $error("write without a valid key started an operation");
  start_taken_a: assert property (go |=> stall && !ack)
    else $error("keyed start did not stall");
  stall_length_a: assert property ($fell(stall) |-> stall_cnt_r == 32'(OP_CYCLES_P))
    else $error("operation length wrong");
  stall_quiet_a: assert property (stall |-> !ack && op_busy)
    else $error("answer or busy wrong during operation");
  done_pulse_a: assert property ($fell(stall) |-> ##[0:1] op_done)
    else $error("no done pulse at end of operation");
  key_hidden_a: assert property (req && op == OP_SFR_RD && sel == SFR_KEY |=> rdata == 16'h0000)
    else $error("key register readable");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read data changed without answer");
  cover property (go);
  cover property ($fell(stall));
  cover property (sfr_wr && sel == SFR_CONTROL && wdata[15] && !go);
  cover property (req && op == OP_TBL_WT_HI);
endmodule : flash_runtime_self_programming_props

// ### test/test_runtime_flash_self_programming.sv
`timescale 1ns/10ps
module test_runtime_flash_self_programming
  import flash_runtime_self_programming_pkg::*;
;
  localparam int          OP_CYC = 64;
  localparam logic [23:0] ROW    = 24'h000080;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic        op_busy;
  logic        op_done;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          cyc        = 0;
  int          busy       = 0;
  flash_runtime_self_programming_if flash_runtime_self_programming_if_inst ();
  flash_runtime_self_programming_device #(.NUM_PANELS(1), .OP_CYCLES_P(OP_CYC)) flash_runtime_self_programming_device_inst (
    .pclk(pclk), .presetn(presetn), .link(flash_runtime_self_programming_if_inst.device), .op_busy(op_busy), .op_done(op_done));
  flash_runtime_self_programming_core flash_runtime_self_programming_core_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .link(flash_runtime_self_programming_if_inst.core));
  flash_runtime_self_programming_props #(.OP_CYCLES_P(OP_CYC)) flash_runtime_self_programming_props_inst (
    .pclk(pclk), .presetn(presetn), .req(flash_runtime_self_programming_if_inst.req), .op(flash_runtime_self_programming_if_inst.op),
    .sel(flash_runtime_self_programming_if_inst.sel), .wdata(flash_runtime_self_programming_if_inst.wdata), .ack(flash_runtime_self_programming_if_inst.ack),
    .rdata(flash_runtime_self_programming_if_inst.rdata), .stall(flash_runtime_self_programming_if_inst.stall), .op_busy(op_busy), .op_done(op_done));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (op_busy === 1'b1) busy++;
    if (cyc == 40000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // The request is held until pready is seen high; a missing answer is left to the watchdog.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
  endtask : rd
  task automatic lop(input core_op_t o, input sfr_sel_t s, input logic b, input logic [23:0] ad, input logic [15:0] d,
                     output logic [15:0] q);
    logic [31:0] r;
    wr(APB_EA, {16'h0, ad[15:0]});
    wr(APB_PAGE, {24'h0, ad[23:16]});
    wr(APB_WDATA, {16'h0, d});
    wr(APB_CMD, {26'h0, s, b, o});
    do rd(APB_STATUS, r); while (r[STAT_PEND_BIT] !== 1'b0);
    rd(APB_RDATA, r);
    q = r[15:0];
  endtask : lop
  task automatic sw(input sfr_sel_t s, input logic [15:0] d);
    logic [15:0] q;
    lop(OP_SFR_WR, s, 1'b0, 24'h0, d, q);
  endtask : sw
  task automatic start(input logic [15:0] ctl, input int exp_busy);
    logic [15:0] q;
    sw(SFR_CONTROL, ctl & 16'h7fff);
    sw(SFR_KEY, 16'h0055);
    sw(SFR_KEY, 16'h00aa);
    busy = 0;
    sw(SFR_CONTROL, ctl);
    chk(busy, exp_busy);
    lop(OP_SFR_RD, SFR_CONTROL, 1'b0, 24'h0, 16'h0, q);
    chk(q[15], 1'b0);
  endtask : start
  // A refused start must neither stall the core nor leave the start bit set.
  task automatic refused(input logic [15:0] ctl);
    logic [15:0] q;
    busy = 0;
    sw(SFR_CONTROL, ctl);
    chk(busy, 0);
    lop(OP_SFR_RD, SFR_CONTROL, 1'b0, 24'h0, 16'h0, q);
    chk(q[15], 1'b0);
  endtask : refused
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd(APB_STATUS, q);
    chk(q, 32'h0);
    rd(APB_IRQ_MSK, q);
    chk(q[1:0], IRQ_RESET);
    apb(8'h20, 1'b0, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(8'h05, 1'b1, 32'h1, q, e);
    chk(e, 1'b1);
  endtask : t_regs
  // Each of the first four attempts breaks the unlock order in one way of its own; the last keeps the key but leaves out the enable bit.
  task automatic t_keys();
    logic [15:0] q;
    sw(SFR_CONTROL, 16'h4041);
    refused(16'hc041);
    sw(SFR_KEY, 16'h0055);
    sw(SFR_ADDR_LOW, 16'h0000);
    sw(SFR_KEY, 16'h00aa);
    refused(16'hc041);
    sw(SFR_KEY, 16'h0055);
    sw(SFR_KEY, 16'h00aa);
    sw(SFR_ADDR_HIGH, 16'h0000);
    refused(16'hc041);
    sw(SFR_KEY, 16'h00aa);
    sw(SFR_KEY, 16'h0055);
    refused(16'hc041);
    sw(SFR_KEY, 16'h0055);
    sw(SFR_KEY, 16'h00aa);
    refused(16'h8041);
    lop(OP_SFR_RD, SFR_KEY, 1'b0, 24'h0, 16'h0, q);
    chk(q, 16'h0);
  endtask : t_keys
  task automatic t_flash();
    logic [15:0] q;
    logic [31:0] r;
    sw(SFR_ADDR_HIGH, {8'h0, ROW[23:16]});
    sw(SFR_ADDR_LOW, ROW[15:0]);
    lop(OP_SFR_RD, SFR_ADDR_LOW, 1'b0, 24'h0, 16'h0, q);
    chk(q, ROW[15:0]);
    start(16'hc041, OP_CYC);
    for (int i = 0; i < 32; i++) begin
      lop(OP_TBL_RD_LO, SFR_CONTROL, 1'b0, ROW + 24'(2 * i), 16'h0, q);
      chk(q, 16'hffff);
      lop(OP_TBL_RD_HI, SFR_CONTROL, 1'b0, ROW + 24'(2 * i), 16'h0, q);
      chk(q, 16'h00ff);
    end
    for (int i = 0; i < 32; i++) begin
      lop(OP_TBL_WT_LO, SFR_CONTROL, 1'b0, ROW + 24'(2 * i), 16'ha500 + 16'(i), q);
      if (i == 0) lop(OP_TBL_WT_LO, SFR_CONTROL, 1'b1, ROW + 24'h1, 16'h005a, q);
      lop(OP_TBL_WT_HI, SFR_CONTROL, 1'b0, ROW + 24'(2 * i), 16'h0030 + 16'(i), q);
    end
    // The last table instruction was the high write to the row's final word.
    lop(OP_SFR_RD, SFR_ADDR_LOW, 1'b0, 24'h0, 16'h0, q);
    chk(q, ROW[15:0] + 16'd62);
    lop(OP_TBL_RD_LO, SFR_CONTROL, 1'b0, ROW, 16'h0, q);
    chk(q, 16'hffff);
    start(16'hc001, OP_CYC);
    for (int i = 0; i < 32; i++) begin
      lop(OP_TBL_RD_LO, SFR_CONTROL, 1'b0, ROW + 24'(2 * i), 16'h0, q);
      chk(q, i == 0 ? 16'h5a00 : 16'ha500 + 16'(i));
      lop(OP_TBL_RD_HI, SFR_CONTROL, 1'b0, ROW + 24'(2 * i), 16'h0, q);
      chk(q, 16'h0030 + 16'(i));
    end
    lop(OP_TBL_RD_LO, SFR_CONTROL, 1'b1, ROW + 24'h1, 16'h0, q);
    chk(q[7:0], 8'h5a);
    lop(OP_TBL_RD_LO, SFR_CONTROL, 1'b0, 24'h123456, 16'h0, q);
    lop(OP_SFR_RD, SFR_ADDR_HIGH, 1'b0, 24'h0, 16'h0, q);
    chk(q[7:0], 8'h12);
    lop(OP_SFR_RD, SFR_ADDR_LOW, 1'b0, 24'h0, 16'h0, q);
    chk(q, 16'h3456);
    rd(APB_IRQ_ST, r);
    chk(r[1:0], 2'b11);
    chk(irq, 1'b0);
    // The interrupt line is registered behind the mask, so it follows one edge after the mask write.
    wr(APB_IRQ_MSK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(APB_IRQ_ST, 32'h3);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd(APB_IRQ_ST, r);
    chk(r[1:0], 2'b00);
  endtask : t_flash
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_keys();
    t_flash();
    test_done();
  end
endmodule : test_runtime_flash_self_programming
